// ==== common/fault_supervisor_defs.svh ====
`ifndef FAULT_SUPERVISOR_DEFS_SVH
`define FAULT_SUPERVISOR_DEFS_SVH

// register byte addresses
`define REG_CTRL      8'h00
`define REG_UVLIM     8'h04
`define REG_OVLIM     8'h08
`define REG_OTLIM     8'h0C
`define REG_PGON      8'h10
`define REG_PGDLY     8'h14
`define REG_SSTIME    8'h18
`define REG_COMP      8'h1C
`define REG_STATUS    8'h20
`define REG_MASK      8'h24
`define REG_STATE     8'h28
`define REG_SINKLIM   8'h2C

// control register fields
`define CTRL_UV_LATCH 0
`define CTRL_OV_LATCH 1
`define CTRL_OT_LATCH 2
// compensation control bit 0: power-good pin bidirectional
`define COMP_PG_BIDIR 0

// status bit positions
`define ST_UV    0
`define ST_OV    1
`define ST_OT    2
`define ST_UVLO  3
`define ST_SLAVE 4
`define ST_PGOOD 5
`define ST_W     6

// reset values
`define RST_UVLIM   16'h0200
`define RST_OVLIM   16'h0700
`define RST_OTLIM   16'h007D
`define RST_PGON    16'h0580
`define RST_PGDLY   16'h0010
`define RST_SSTIME  16'h0100
`define RST_SINKLIM 16'h0630

// timing: hiccup off interval in microseconds, converted at 10 MHz
`define HICCUP_OFF_US   1000
`define CLK_MHZ         10
`define HICCUP_OFF_CYC  (`HICCUP_OFF_US * `CLK_MHZ)
// soft-start and delay counts tick every TICK_CYC clocks
`define TICK_CYC        16'h0064

`endif

// ==== common/fault_supervisor_pkg.sv ====
package fault_supervisor_pkg;
	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_SOFT    = 3'b001,
		ST_RUN     = 3'b010,
		ST_HICCUP  = 3'b011,
		ST_LATCHED = 3'b100
	} sup_state_t;

	typedef struct packed {
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [3:0]  sel;
		logic        we;
		logic        req;
	} bus_req_t;

	typedef struct packed {
		logic uv;
		logic ov;
		logic ot;
		logic uvlo;
		logic slave;
	} fault_set_t;
endpackage : fault_supervisor_pkg

// ==== verilog/tick_divider.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fault_supervisor_defs.svh"
module tick_divider #(
	parameter logic [15:0] DIV = `TICK_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clear,
	output var  logic tick
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic        next_tick;

	always_comb begin
		next_tick  = 1'b0;
		next_count = count + 16'h0001;
		if (clear) begin
			next_count = 16'h0000;
		end else if (count >= DIV - 16'h0001) begin
			next_count = 16'h0000;
			next_tick  = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 16'h0000;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule : tick_divider
`default_nettype wire

// ==== verilog/converter_fault_supervisor.sv ====
// What this block does
// - flag undervoltage when feedback below limit
// - undervoltage goes hiccup or latch-off per setting
// - latched off until bias or control cycled
// - sink mode above 5% over reference
// - sink mode forces continuous conduction
// - high-side turn-on ends sink mode
// - overtemperature goes hiccup or latch-off
// - compensation bit 0 picks pin direction
// - bidirectional pin senses slave phase faults
// - power good low once input applied
// - power good after threshold plus delay
// - protection faults latch power good low
// - only new soft start releases power good
// - input supply failure latches power good low
// - soft-start time programmable, restarts power good
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "fault_supervisor_defs.svh"
module converter_fault_supervisor
	import fault_supervisor_pkg::*;
#(
	parameter int HICCUP_CYC = `HICCUP_OFF_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	input  wire logic [15:0] feedback_sense,
	input  wire logic [15:0] temp_sense,
	input  wire logic        vin_ok,
	input  wire logic        enable_in,
	input  wire logic        high_side_switch,
	input  wire logic        power_good_pin_i,
	output var  logic        power_good_pin_o,
	output var  logic        power_good_pin_oe,
	output var  logic        switching_en,
	output var  logic        forced_ccm,
	output var  logic        output_sinking_state,
	output var  logic        irq
);
	bus_req_t   req;
	sup_state_t state;
	sup_state_t next_state;
	fault_set_t fault;

	logic [2:0]  respLatch;
	logic [15:0] uvLimit, ovLimit, otLimit, pgOn, pgDelay, ssTime, sinkLimit;
	logic        pgBidir;
	logic [`ST_W-1:0] status, mask;
	logic [31:0] next_dat;
	logic        next_ack;

	logic [31:0] waitCount;
	logic [31:0] next_waitCount;
	logic [15:0] tickCount;
	logic [15:0] next_tickCount;
	logic        pgood;
	logic        next_pgood;
	logic        sink;
	logic        next_sink;
	logic        enPrev;
	logic        tick;
	logic        anyFault;
	logic        latchSel;
	logic        wr;

	function automatic logic [15:0] lane_write(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		lane_write = {sel[1] ? dat[15:8] : old[15:8],
			sel[0] ? dat[7:0] : old[7:0]};
	endfunction : lane_write

	assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i,
		we: wb_we_i, req: wb_cyc_i & wb_stb_i};
	assign wr = req.req & req.we & ~wb_ack_o;

	// fault detection from analog-facing samples
	always_comb begin
		fault.uv    = state == ST_RUN && feedback_sense < uvLimit;
		fault.ov    = state != ST_OFF && feedback_sense > ovLimit;
		fault.ot    = temp_sense > otLimit;
		fault.uvlo  = ~vin_ok;
		// the shared line reads low while a slave phase pulls it down
		fault.slave = pgBidir & pgood & ~power_good_pin_i;
	end
	assign anyFault = fault.uv | fault.ov | fault.ot | fault.slave;
	// chosen response: latch if any active fault is set to latch-off; a slave fault always latches
	assign latchSel = (fault.uv & respLatch[`CTRL_UV_LATCH])
		| (fault.ov & respLatch[`CTRL_OV_LATCH])
		| (fault.ot & respLatch[`CTRL_OT_LATCH])
		| fault.slave;

	tick_divider u_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.clear (state != next_state),
		.tick  (tick)
	);

	// sequencer
	always_comb begin
		next_state     = state;
		next_waitCount = waitCount;
		next_tickCount = tickCount;
		next_pgood     = pgood;
		unique case (state)
			ST_OFF: begin
				next_pgood = 1'b0;
				if (enable_in && vin_ok) begin
					next_state     = ST_SOFT;
					next_tickCount = 16'h0000;
				end
			end
			ST_SOFT: begin
				if (tick) begin
					next_tickCount = tickCount + 16'h0001;
				end
				if (tickCount >= ssTime) begin
					next_state     = ST_RUN;
					next_tickCount = 16'h0000;
				end
			end
			ST_RUN: begin
				if (!pgood && feedback_sense >= pgOn && tick) begin
					next_tickCount = tickCount + 16'h0001;
				end
				if (!pgood && feedback_sense >= pgOn
					&& tickCount >= pgDelay) begin
					next_pgood = 1'b1;
				end
			end
			ST_HICCUP: begin
				next_waitCount = waitCount + 32'h0000_0001;
				if (waitCount >= 32'(HICCUP_CYC - 1)) begin
					next_state     = ST_SOFT;
					next_tickCount = 16'h0000;
				end
			end
			ST_LATCHED: begin
				// stays here until enable is dropped or reset
				if (!enable_in) begin
					next_state = ST_OFF;
				end
			end
			default: next_state = ST_OFF;
		endcase
		if (state != ST_OFF && state != ST_LATCHED) begin
			if (!vin_ok || !enable_in) begin
				next_state = ST_OFF;
				next_pgood = 1'b0;
			end else if (anyFault) begin
				next_pgood     = 1'b0;
				next_waitCount = 32'h0000_0000;
				next_state     = latchSel ? ST_LATCHED : ST_HICCUP;
			end
		end
		if (state == ST_HICCUP || state == ST_LATCHED) begin
			next_pgood = 1'b0;
		end
	end

	// sink mode: above 5% over reference, below trip level
	always_comb begin
		next_sink = sink;
		if (state == ST_RUN && feedback_sense > sinkLimit
			&& feedback_sense <= ovLimit) begin
			next_sink = 1'b1;
		end
		if (high_side_switch || state != ST_RUN) begin
			next_sink = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ST_OFF;
			waitCount <= 32'h0000_0000;
			tickCount <= 16'h0000;
			pgood     <= 1'b0;
			sink      <= 1'b0;
			enPrev    <= 1'b0;
		end else begin
			state     <= next_state;
			waitCount <= next_waitCount;
			tickCount <= next_tickCount;
			pgood     <= next_pgood;
			sink      <= next_sink;
			enPrev    <= enable_in;
		end
	end

	// pin and converter outputs, all registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_good_pin_o     <= 1'b0;
			power_good_pin_oe    <= 1'b0;
			switching_en         <= 1'b0;
			forced_ccm           <= 1'b0;
			output_sinking_state <= 1'b0;
			irq                  <= 1'b0;
		end else begin
			// open drain: enable low drives the pin low
			power_good_pin_o     <= 1'b0;
			power_good_pin_oe    <= next_pgood;
			switching_en         <= next_state == ST_SOFT
				|| next_state == ST_RUN;
			forced_ccm           <= next_sink;
			output_sinking_state <= next_sink;
			irq                  <= |(status & mask);
		end
	end

	// register file; fault set wins over write-one-to-clear
	logic [`ST_W-1:0] evt;
	logic [`ST_W-1:0] next_status;
	assign evt = {pgood & ~next_pgood, fault.slave, fault.uvlo & enPrev,
		fault.ot, fault.ov, fault.uv};
	always_comb begin
		next_status = status;
		if (wr && req.adr == `REG_STATUS && req.sel[0]) begin
			next_status = status & ~req.dat[`ST_W-1:0];
		end
		next_status = next_status | evt;
	end

	always_comb begin
		next_ack = req.req & ~wb_ack_o;
		unique case (req.adr)
			`REG_CTRL:    next_dat = {29'h0, respLatch};
			`REG_UVLIM:   next_dat = {16'h0, uvLimit};
			`REG_OVLIM:   next_dat = {16'h0, ovLimit};
			`REG_OTLIM:   next_dat = {16'h0, otLimit};
			`REG_PGON:    next_dat = {16'h0, pgOn};
			`REG_PGDLY:   next_dat = {16'h0, pgDelay};
			`REG_SSTIME:  next_dat = {16'h0, ssTime};
			`REG_COMP:    next_dat = {31'h0, pgBidir};
			`REG_STATUS:  next_dat = {26'h0, status};
			`REG_MASK:    next_dat = {26'h0, mask};
			`REG_STATE:   next_dat = {26'h0, sink, pgood, 1'b0, state};
			`REG_SINKLIM: next_dat = {16'h0, sinkLimit};
			default:      next_dat = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
			respLatch <= 3'h0;
			uvLimit   <= `RST_UVLIM;
			ovLimit   <= `RST_OVLIM;
			otLimit   <= `RST_OTLIM;
			pgOn      <= `RST_PGON;
			pgDelay   <= `RST_PGDLY;
			ssTime    <= `RST_SSTIME;
			sinkLimit <= `RST_SINKLIM;
			pgBidir   <= 1'b0;
			status    <= '0;
			mask      <= '0;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			status   <= next_status;
			if (wr) begin
				unique case (req.adr)
					`REG_CTRL: if (req.sel[0]) respLatch <= req.dat[2:0];
					`REG_UVLIM:   uvLimit   <= lane_write(uvLimit, req.dat, req.sel);
					`REG_OVLIM:   ovLimit   <= lane_write(ovLimit, req.dat, req.sel);
					`REG_OTLIM:   otLimit   <= lane_write(otLimit, req.dat, req.sel);
					`REG_PGON:    pgOn      <= lane_write(pgOn, req.dat, req.sel);
					`REG_PGDLY:   pgDelay   <= lane_write(pgDelay, req.dat, req.sel);
					`REG_SSTIME:  ssTime    <= lane_write(ssTime, req.dat, req.sel);
					`REG_SINKLIM: sinkLimit <= lane_write(sinkLimit, req.dat, req.sel);
					`REG_COMP: if (req.sel[0]) pgBidir <= req.dat[`COMP_PG_BIDIR];
					`REG_MASK: if (req.sel[0]) mask <= req.dat[`ST_W-1:0];
					default: ;
				endcase
			end
		end
	end

	property p_uv_pgood;
		@(posedge clk) disable iff (!rst_n)
		(state == ST_RUN && fault.uv && enable_in && vin_ok)
			|=> (state inside {ST_HICCUP, ST_LATCHED}) && !pgood;
	endproperty
	a_uv_pgood: assert property (p_uv_pgood) else $error("uv not handled");

	property p_uv_latch;
		@(posedge clk) disable iff (!rst_n)
		(state == ST_RUN && fault.uv && respLatch[`CTRL_UV_LATCH]
			&& enable_in && vin_ok) |=> state == ST_LATCHED;
	endproperty
	a_uv_latch: assert property (p_uv_latch) else $error("uv latch missed");

	property p_latched_stays;
		@(posedge clk) disable iff (!rst_n)
		(state == ST_LATCHED && enable_in) |=> state == ST_LATCHED;
	endproperty
	a_latched_stays: assert property (p_latched_stays) else $error("left latch");

	property p_sink_ccm;
		@(posedge clk) disable iff (!rst_n)
		output_sinking_state |-> forced_ccm;
	endproperty
	a_sink_ccm: assert property (p_sink_ccm) else $error("sink without ccm");

	property p_sink_exit;
		@(posedge clk) disable iff (!rst_n)
		// both registered at one edge; sinking may re-enter afterwards
		high_side_switch |=> !sink && !output_sinking_state;
	endproperty
	a_sink_exit: assert property (p_sink_exit) else $error("sink kept");

	property p_pg_off_low;
		@(posedge clk) disable iff (!rst_n)
		(state == ST_OFF) |=> !power_good_pin_oe ##0 !pgood;
	endproperty
	a_pg_off_low: assert property (p_pg_off_low) else $error("pg high off");

	property p_pg_rise;
		@(posedge clk) disable iff (!rst_n)
		$rose(pgood) |-> $past(feedback_sense) >= $past(pgOn)
			&& $past(state) == ST_RUN;
	endproperty
	a_pg_rise: assert property (p_pg_rise) else $error("pg rose early");

	property p_pg_latched;
		@(posedge clk) disable iff (!rst_n)
		(state == ST_HICCUP || state == ST_LATCHED) |-> !pgood;
	endproperty
	a_pg_latched: assert property (p_pg_latched) else $error("pg in fault");

	property p_uvlo;
		@(posedge clk) disable iff (!rst_n)
		!vin_ok |=> !pgood ##1 !power_good_pin_oe;
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("pg high at uvlo");

	property p_hiccup_off;
		@(posedge clk) disable iff (!rst_n)
		$rose(state == ST_HICCUP) |=> !switching_en [*3];
	endproperty
	a_hiccup_off: assert property (p_hiccup_off) else $error("hiccup switching");
endmodule : converter_fault_supervisor
`default_nettype wire

// ==== testbench/slave_phase_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module slave_phase_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic faultReq,
	output var  logic pullOe
);
	logic next_pullOe;

	// open drain: low pulls the shared line down, high leaves it to the pull-up
	always_comb begin
		next_pullOe = !faultReq;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pullOe <= 1'b1;
		end else begin
			pullOe <= next_pullOe;
		end
	end
endmodule : slave_phase_model
`default_nettype wire

// ==== testbench/tb_converter_fault_supervisor.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fault_supervisor_defs.svh"
module tb_converter_fault_supervisor
	import fault_supervisor_pkg::*;
;
	localparam int HCYC = 20;
	logic        clk, rstN, cyc, stb, we, ack, vinOk, enable, hsSw;
	logic        pgO, pgOe, swEn, ccm, sink, irq, slaveFault, slaveOe;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [15:0] fb, temp;
	logic [31:0] wdat, rdat, q;
	wire logic   pgLine;
	int          failures, checks, cycles, n;
	logic [7:0]  rAdr [8] = '{`REG_UVLIM, `REG_OVLIM, `REG_OTLIM, `REG_PGON,
		`REG_PGDLY, `REG_SSTIME, `REG_SINKLIM, 8'h30};
	logic [15:0] rVal [8] = '{`RST_UVLIM, `RST_OVLIM, `RST_OTLIM, `RST_PGON,
		`RST_PGDLY, `RST_SSTIME, `RST_SINKLIM, 16'h0000};

	// pull-up wins unless some party drives low
	assign pgLine = (pgOe ? 1'b1 : pgO) & slaveOe;

	converter_fault_supervisor #(.HICCUP_CYC(HCYC)) dut_u (
		.clk(clk), .rst_n(rstN), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .feedback_sense(fb),
		.temp_sense(temp), .vin_ok(vinOk), .enable_in(enable),
		.high_side_switch(hsSw), .power_good_pin_i(pgLine),
		.power_good_pin_o(pgO), .power_good_pin_oe(pgOe),
		.switching_en(swEn), .forced_ccm(ccm),
		.output_sinking_state(sink), .irq(irq));

	slave_phase_model partner_u (.clk(clk), .rst_n(rstN),
		.faultReq(slaveFault), .pullOe(slaveOe));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures = failures + 1;
			$display("MISMATCH at %0t timeout got %h exp %h", $time, cycles, 0);
			results();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		sel <= 4'h3;
		// ack and read data are taken at the same rising edge
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20) chk(32'h0, 32'h1);
	endtask : xfer

	function automatic logic pick(input int s);
		return (s == 0) ? pgOe : (s == 1) ? swEn : sink;
	endfunction : pick

	// counts negedges until the output shows v, gives up at lim
	task waitFor(input int s, input logic v, input int lim);
		n = 0;
		@(negedge clk);
		while (pick(s) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk({31'h0, pick(s)}, {31'h0, v});
		// next stimulus lands on a rising edge
		@(posedge clk);
	endtask : waitFor

	task restart;
		@(posedge clk);
		enable <= 1'b0;
		@(posedge clk);
		enable <= 1'b1;
		waitFor(0, 1'b1, 1000);
	endtask : restart

	initial begin
		{failures, checks, cycles} = '0;
		{rstN, cyc, stb, we, enable, hsSw, slaveFault} = '0;
		{adr, sel, wdat, fb} = '0;
		temp = 16'h0040;
		vinOk = 1'b1;
		repeat (4) @(posedge clk);
		chk({31'h0, pgOe}, 32'h0);
		chk({31'h0, pgO}, 32'h0);
		rstN <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			xfer(rAdr[i], 1'b0, 16'h0000);
			chk(q, {16'h0000, rVal[i]});
		end
		$display("test register reset done");
		xfer(`REG_SSTIME, 1'b1, 16'h0002);
		xfer(`REG_PGDLY, 1'b1, 16'h0001);
		xfer(`REG_MASK, 1'b1, 16'h003F);
		fb <= 16'h0600;
		enable <= 1'b1;
		waitFor(0, 1'b1, 1000);
		// two soft-start ticks plus one delay tick at the least
		chk({31'h0, n >= 3 * `TICK_CYC}, 32'h1);
		xfer(`REG_STATE, 1'b0, 16'h0000);
		chk(q, {26'h0, 3'b010, ST_RUN});
		$display("test startup done");
		fb <= 16'h0630;
		repeat (5) @(negedge clk);
		chk({31'h0, sink}, 32'h0);
		@(posedge clk);
		fb <= 16'h0680;
		waitFor(2, 1'b1, 10);
		chk({31'h0, ccm}, 32'h1);
		// below the band too, so only the turn-on can end sinking
		hsSw <= 1'b1;
		fb <= 16'h0600;
		@(posedge clk);
		hsSw <= 1'b0;
		waitFor(2, 1'b0, 10);
		$display("test sinking done");
		xfer(`REG_CTRL, 1'b1, 16'h0000);
		fb <= 16'h0100;
		waitFor(0, 1'b0, 10);
		waitFor(1, 1'b0, 10);
		waitFor(1, 1'b1, HCYC + 10);
		chk({31'h0, n >= HCYC - 2}, 32'h1);
		fb <= 16'h0600;
		waitFor(0, 1'b1, 1000);
		chk({31'h0, n >= 100}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		xfer(`REG_STATUS, 1'b0, 16'h0000);
		chk(q & 32'h1, 32'h1);
		xfer(`REG_STATUS, 1'b1, 16'h003F);
		xfer(`REG_STATUS, 1'b0, 16'h0000);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test hiccup done");
		xfer(`REG_CTRL, 1'b1, 16'h0002);
		xfer(`REG_MASK, 1'b1, 16'h0000);
		fb <= 16'h0800;
		waitFor(1, 1'b0, 10);
		chk({31'h0, pgOe}, 32'h0);
		fb <= 16'h0600;
		repeat (3 * HCYC) @(negedge clk);
		chk({31'h0, swEn}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		xfer(`REG_MASK, 1'b1, 16'h003F);
		// irq follows the mask one edge later
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		xfer(`REG_STATUS, 1'b1, 16'h003F);
		restart();
		$display("test overvoltage done");
		xfer(`REG_CTRL, 1'b1, 16'h0004);
		temp <= 16'h0100;
		waitFor(1, 1'b0, 10);
		temp <= 16'h0040;
		repeat (3 * HCYC) @(negedge clk);
		chk({31'h0, swEn}, 32'h0);
		restart();
		$display("test temperature done");
		vinOk <= 1'b0;
		waitFor(0, 1'b0, 10);
		vinOk <= 1'b1;
		xfer(`REG_STATUS, 1'b0, 16'h0000);
		chk(q & 32'h8, 32'h8);
		waitFor(0, 1'b1, 1000);
		xfer(`REG_STATUS, 1'b1, 16'h003F);
		$display("test supply done");
		xfer(`REG_COMP, 1'b1, 16'h0001);
		slaveFault <= 1'b1;
		waitFor(1, 1'b0, 10);
		slaveFault <= 1'b0;
		repeat (20) @(negedge clk);
		chk({31'h0, pgOe}, 32'h0);
		restart();
		xfer(`REG_COMP, 1'b1, 16'h0000);
		slaveFault <= 1'b1;
		repeat (20) @(negedge clk);
		chk({31'h0, swEn}, 32'h1);
		@(posedge clk);
		slaveFault <= 1'b0;
		$display("test shared pin done");
		// latch off, then a mid-run reset stands for the bias cycle
		temp <= 16'h0100;
		waitFor(1, 1'b0, 10);
		temp <= 16'h0040;
		rstN <= 1'b0;
		@(negedge clk);
		chk({29'h0, pgO, pgOe, swEn}, 32'h0);
		@(posedge clk);
		rstN <= 1'b1;
		xfer(`REG_SSTIME, 1'b1, 16'h0002);
		xfer(`REG_PGDLY, 1'b1, 16'h0001);
		waitFor(0, 1'b1, 1000);
		$display("test reset restart done");
		results();
	end
endmodule : tb_converter_fault_supervisor
`default_nettype wire
